// ---- rtl/kbo_pkg.sv ----
// Package of constants for the keyboard controller output-port command block
package kbo_pkg;

	// ==========================================
	// Command codes
	localparam logic [7:0] CMD_POLL_HIGH  = 8'hc2;
	localparam logic [7:0] CMD_POLL_LOW   = 8'hc3;
	localparam logic [7:0] CMD_READ_OUT   = 8'hd0;
	localparam logic [7:0] CMD_WRITE_OUT  = 8'hd1;
	localparam logic [7:0] CMD_ECHO_KBD   = 8'hd2;
	localparam logic [7:0] CMD_ECHO_PTR   = 8'hd3;
	localparam logic [7:0] CMD_WRITE_PTR  = 8'hd4;
	localparam logic [7:0] CMD_READ_TEST  = 8'he0;
	localparam logic [3:0] CMD_PULSE_HI   = 4'hf;

	// ==========================================
	// Output port image fields
	localparam int OUT_KBD_DATA  = 7;
	localparam int OUT_KBD_CLK   = 6;
	localparam int OUT_PTR_IRQ   = 5;
	localparam int OUT_KBD_IRQ   = 4;
	localparam int OUT_PTR_CLK   = 3;
	localparam int OUT_PTR_DATA  = 2;
	localparam int OUT_GATE_A    = 1;
	localparam int OUT_SYS_RESET = 0;
	localparam logic OUT_GATE_RESET = 1'b1;

	// ==========================================
	// Timing
	localparam int CLK_PERIOD_NS  = 50;
	localparam int PULSE_TIME_NS  = 6000;
	localparam int PULSE_CYCLES   = (PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================
	// Command sequencer states; kbo_state_t Gray coded, kbo_pend_t and kbo_poll_t binary
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WAIT  = 2'b01,
		ST_PULSE = 2'b11
	} kbo_state_t;

	typedef enum logic [2:0] {
		PD_NONE   = 3'h0,
		PD_WROUT  = 3'h1,
		PD_ECHOK  = 3'h2,
		PD_ECHOP  = 3'h3,
		PD_WRPTR  = 3'h4
	} kbo_pend_t;

	typedef enum logic [1:0] {
		PL_NONE = 2'h0,
		PL_HIGH = 2'h1,
		PL_LOW  = 2'h2
	} kbo_poll_t;

endpackage

// ---- rtl/kbo_pulse.sv ----
// Pulse timer for the output port pulse commands
`timescale 1ns/1ps
module kbo_pulse #(
	parameter int CYCLES = kbo_pkg::PULSE_CYCLES
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Control
	input  wire logic       start,
	input  wire logic [3:0] sel,
	// Result
	output logic      [3:0] pulse,
	output logic            busy
);
	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic [3:0]    next_pulse;

	// ==========================================
	// Next values
	always_comb begin
		next_count = count;
		next_pulse = pulse;
		if (start && count == '0) begin
			next_count = CW'(CYCLES);
			next_pulse = ~sel;
		end else if (count != '0) begin
			next_count = count - 1'b1;
			if (count == CW'(1))
				next_pulse = 4'h0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
			pulse <= 4'h0;
		end else begin
			count <= next_count;
			pulse <= next_pulse;
		end
	end

	assign busy = (count != '0);
endmodule

// ---- rtl/kbo_cmd.sv ----
// Command interpreter for the output port and echo commands
`timescale 1ns/1ps
// Summary of operation
// - Command C3h keeps copying input port bits 3..0 into the low half of the status byte.
// - Input port polling keeps refreshing until any other command arrives.
// - Command D0h loads the output port image into the output buffer for reading at the data port.
// - Output port bits 7..2 show keyboard data, keyboard clock, pointer irq, keyboard irq, pointer clock, pointer data.
// - Output port bit 1 drives the address bit twenty gate, 0 holds low and 1 passes.
// - Output port bit 0 reports the system reset line, 1 when active.
// - After D1h the next data byte updates only bit 1 of the output port.
// - After D2h the next data byte returns as keyboard data, untranslated, raising the keyboard irq if enabled.
// - After D3h the next data byte returns as pointer data, raising the pointer irq if enabled.
// - After D4h the next data byte is sent to the pointing device.
// - Command E0h places test inputs 1 and 0 into output buffer bits 1 and 0.
// - Commands F0h..FFh pulse PULSE_OUT bits 3..0 where the command bit is 0; only bits 1 and 0 reach the output port.
// - A pulse on output port bit 0 resets the whole system.
module kbo_cmd #(
	parameter int PULSE_LEN = kbo_pkg::PULSE_CYCLES
) (
	// Clock and reset
	input  wire logic       CLK,
	input  wire logic       RSTN,
	// Host port writes and output buffer read
	input  wire logic       CMD_WR,
	input  wire logic       DATA_WR,
	input  wire logic [7:0] HOST_DIN,
	input  wire logic       OBUF_RD,
	// Device lines and inputs
	input  wire logic [7:0] INPUT_PORT,
	input  wire logic [1:0] TEST_IN,
	input  wire logic       KBD_DATA_IN,
	input  wire logic       KBD_CLK_IN,
	input  wire logic       PTR_DATA_IN,
	input  wire logic       PTR_CLK_IN,
	input  wire logic       KBD_IRQ_EN,
	input  wire logic       PTR_IRQ_EN,
	// Host read side
	output logic      [7:0] OBUF,
	output logic            OBUF_FULL,
	output logic            OBUF_FROM_PTR,
	output logic      [7:0] STATUS_POLL,
	output logic      [7:0] OUT_PORT,
	// System lines
	output logic            ADDR_BIT_TWENTY_GATE,
	output logic            SYS_RESET,
	output logic            KEYBOARD_INTERRUPT_LINE,
	output logic            POINTER_INTERRUPT_LINE,
	output logic      [7:0] PTR_TX_DATA,
	output logic            PTR_TX_STB,
	output logic      [3:0] PULSE_OUT
);
	logic       rst_m;
	logic       rst_n;

	// ==========================================
	// Reset release
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_m <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_m <= 1'b1;
			rst_n <= rst_m;
		end
	end

	kbo_pkg::kbo_pend_t pend, next_pend;
	kbo_pkg::kbo_poll_t poll, next_poll;
	logic       gate, next_gate;
	logic [7:0] obuf_n;
	logic       full_n, ptr_n;
	logic [7:0] stat_n;
	logic       kirq_n, pirq_n;
	logic [7:0] ptx_n;
	logic       pstb_n;
	logic       pulse_go;
	logic [3:0] pulse;
	logic       pulse_busy;
	logic [7:0] port_img;

	// Bit 0 pulse is the only source of system reset
	kbo_pulse #(.CYCLES(PULSE_LEN)) u_pulse (
		.clk   (CLK),
		.rst_n (rst_n),
		.start (pulse_go),
		.sel   (HOST_DIN[3:0]),
		.pulse (pulse),
		.busy  (pulse_busy)
	);

	// ==========================================
	// Output port image
	function automatic logic [7:0] port_image(input logic g, input logic [3:0] p);
		logic [7:0] v;
		v = 8'h00;
		v[kbo_pkg::OUT_KBD_DATA] = KBD_DATA_IN;
		v[kbo_pkg::OUT_KBD_CLK]  = KBD_CLK_IN;
		v[kbo_pkg::OUT_PTR_IRQ]  = POINTER_INTERRUPT_LINE;
		v[kbo_pkg::OUT_KBD_IRQ]  = KEYBOARD_INTERRUPT_LINE;
		v[kbo_pkg::OUT_PTR_CLK]  = PTR_CLK_IN;
		v[kbo_pkg::OUT_PTR_DATA] = PTR_DATA_IN;
		v[kbo_pkg::OUT_GATE_A]    = g ^ p[kbo_pkg::OUT_GATE_A];
		v[kbo_pkg::OUT_SYS_RESET] = p[kbo_pkg::OUT_SYS_RESET];
		return v;
	endfunction

	// Comb process, so line levels read inside the function wake it
	always_comb port_img = port_image(gate, pulse);

	// ==========================================
	// Command decode and data capture
	always_comb begin
		next_pend = pend;
		next_poll = poll;
		next_gate = gate;
		obuf_n    = OBUF;
		full_n    = OBUF_FULL && !OBUF_RD;
		ptr_n     = OBUF_FROM_PTR;
		stat_n    = STATUS_POLL;
		kirq_n    = KEYBOARD_INTERRUPT_LINE && !OBUF_RD;
		pirq_n    = POINTER_INTERRUPT_LINE && !OBUF_RD;
		ptx_n     = PTR_TX_DATA;
		pstb_n    = 1'b0;
		pulse_go  = 1'b0;
		case (poll)
			kbo_pkg::PL_HIGH: stat_n[7:4] = INPUT_PORT[7:4];
			kbo_pkg::PL_LOW:  stat_n[3:0] = INPUT_PORT[3:0];
			default:          stat_n = STATUS_POLL;
		endcase
		if (CMD_WR) begin
			next_pend = kbo_pkg::PD_NONE;
			next_poll = kbo_pkg::PL_NONE;
			case (HOST_DIN)
				kbo_pkg::CMD_POLL_HIGH: next_poll = kbo_pkg::PL_HIGH;
				kbo_pkg::CMD_POLL_LOW:  next_poll = kbo_pkg::PL_LOW;
				kbo_pkg::CMD_READ_OUT: begin
					obuf_n = port_img;
					full_n = 1'b1;
					ptr_n  = 1'b0;
				end
				kbo_pkg::CMD_WRITE_OUT: next_pend = kbo_pkg::PD_WROUT;
				kbo_pkg::CMD_ECHO_KBD:  next_pend = kbo_pkg::PD_ECHOK;
				kbo_pkg::CMD_ECHO_PTR:  next_pend = kbo_pkg::PD_ECHOP;
				kbo_pkg::CMD_WRITE_PTR: next_pend = kbo_pkg::PD_WRPTR;
				kbo_pkg::CMD_READ_TEST: begin
					obuf_n = {6'h00, TEST_IN};
					full_n = 1'b1;
					ptr_n  = 1'b0;
				end
				default: begin
					if (HOST_DIN[7:4] == kbo_pkg::CMD_PULSE_HI && !pulse_busy)
						pulse_go = 1'b1;
				end
			endcase
		end else if (DATA_WR) begin
			next_pend = kbo_pkg::PD_NONE;
			case (pend)
				kbo_pkg::PD_WROUT: next_gate = HOST_DIN[kbo_pkg::OUT_GATE_A];
				kbo_pkg::PD_ECHOK: begin
					obuf_n = HOST_DIN;
					full_n = 1'b1;
					ptr_n  = 1'b0;
					kirq_n = KBD_IRQ_EN;
				end
				kbo_pkg::PD_ECHOP: begin
					obuf_n = HOST_DIN;
					full_n = 1'b1;
					ptr_n  = 1'b1;
					pirq_n = PTR_IRQ_EN;
				end
				kbo_pkg::PD_WRPTR: begin
					ptx_n  = HOST_DIN;
					pstb_n = 1'b1;
				end
				default: next_pend = kbo_pkg::PD_NONE;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			pend                    <= kbo_pkg::PD_NONE;
			poll                    <= kbo_pkg::PL_NONE;
			gate                    <= kbo_pkg::OUT_GATE_RESET;
			OBUF                    <= 8'h00;
			OBUF_FULL               <= 1'b0;
			OBUF_FROM_PTR           <= 1'b0;
			STATUS_POLL             <= 8'h00;
			KEYBOARD_INTERRUPT_LINE <= 1'b0;
			POINTER_INTERRUPT_LINE  <= 1'b0;
			PTR_TX_DATA             <= 8'h00;
			PTR_TX_STB              <= 1'b0;
			OUT_PORT                <= 8'h00;
			ADDR_BIT_TWENTY_GATE    <= 1'b0;
			SYS_RESET               <= 1'b0;
			PULSE_OUT               <= 4'h0;
		end else begin
			pend                    <= next_pend;
			poll                    <= next_poll;
			gate                    <= next_gate;
			OBUF                    <= obuf_n;
			OBUF_FULL               <= full_n;
			OBUF_FROM_PTR           <= ptr_n;
			STATUS_POLL             <= stat_n;
			KEYBOARD_INTERRUPT_LINE <= kirq_n;
			POINTER_INTERRUPT_LINE  <= pirq_n;
			PTR_TX_DATA             <= ptx_n;
			PTR_TX_STB              <= pstb_n;
			OUT_PORT                <= port_img;
			ADDR_BIT_TWENTY_GATE    <= port_img[kbo_pkg::OUT_GATE_A];
			SYS_RESET               <= pulse[kbo_pkg::OUT_SYS_RESET];
			PULSE_OUT               <= pulse;
		end
	end
endmodule

// ---- tb/kbo_cmd_asserts.sv ----
// Port checker for the command block
`timescale 1ns/1ps
module kbo_chk #(
	parameter int PULSE_LEN = 4
) (
	// Watched ports
	input wire logic       CLK,
	input wire logic       RSTN,
	input wire logic       CMD_WR,
	input wire logic       DATA_WR,
	input wire logic [7:0] HOST_DIN,
	input wire logic [1:0] TEST_IN,
	input wire logic [7:0] INPUT_PORT,
	input wire logic       KBD_IRQ_EN,
	input wire logic [7:0] OBUF,
	input wire logic       OBUF_FULL,
	input wire logic [7:0] STATUS_POLL,
	input wire logic       ADDR_BIT_TWENTY_GATE,
	input wire logic       SYS_RESET,
	input wire logic       KEYBOARD_INTERRUPT_LINE,
	input wire logic [7:0] PTR_TX_DATA,
	input wire logic       PTR_TX_STB,
	input wire logic [3:0] PULSE_OUT
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	// ==========
	// Reset pulse width counter
	int cnt;
	always_ff @(posedge CLK or negedge RSTN)
		if (!RSTN)
			cnt <= 0;
		else
			cnt <= SYS_RESET ? cnt + 1 : 0;
	a_read_out_port: assert property (CMD_WR && HOST_DIN == 8'hd0
		|=> OBUF_FULL && OBUF[1] == ADDR_BIT_TWENTY_GATE) else $error("output port read not loaded");
	a_test_in_bits: assert property (CMD_WR && HOST_DIN == 8'he0
		|=> OBUF_FULL && OBUF[1:0] == $past(TEST_IN)) else $error("test inputs not loaded");
	a_ptr_send_once: assert property (CMD_WR && HOST_DIN == 8'hd4 ##1 DATA_WR && !CMD_WR
		|=> PTR_TX_STB && PTR_TX_DATA == $past(HOST_DIN) ##1 !PTR_TX_STB) else $error("pointer byte wrong");
	a_echo_kbd_irq: assert property (CMD_WR && HOST_DIN == 8'hd2 ##1 DATA_WR && !CMD_WR
		|=> OBUF_FULL && OBUF == $past(HOST_DIN) && KEYBOARD_INTERRUPT_LINE == $past(KBD_IRQ_EN)) else $error("echo wrong");
	a_gate_write: assert property (CMD_WR && HOST_DIN == 8'hd1 ##1 DATA_WR && !CMD_WR
		|-> ##3 ADDR_BIT_TWENTY_GATE == $past(HOST_DIN[1], 3)) else $error("gate not written");
	// Polled half is one register stage behind the input port
	a_poll_low_half: assert property (CMD_WR && HOST_DIN == 8'hc3 ##1 !CMD_WR [*4]
		|-> STATUS_POLL[3:0] == $past(INPUT_PORT[3:0])) else $error("poll half stale");
	a_pulse_select: assert property (CMD_WR && HOST_DIN[7:4] == 4'hf && PULSE_OUT == 4'h0 && !SYS_RESET
		|=> ##1 PULSE_OUT == ~$past(HOST_DIN[3:0], 2)) else $error("pulse bits wrong");
	a_reset_width: assert property ($fell(SYS_RESET) |-> cnt == PULSE_LEN)
		else $error("reset pulse width wrong");
endmodule
bind kbo_cmd kbo_chk #(.PULSE_LEN(PULSE_LEN)) chk (.CLK, .RSTN, .CMD_WR, .DATA_WR, .HOST_DIN, .TEST_IN,
	.INPUT_PORT, .KBD_IRQ_EN, .OBUF, .OBUF_FULL, .STATUS_POLL, .ADDR_BIT_TWENTY_GATE, .SYS_RESET,
	.KEYBOARD_INTERRUPT_LINE, .PTR_TX_DATA, .PTR_TX_STB, .PULSE_OUT);

// ---- tb/kbo_host.sv ----
// Host model writing the command and data ports
`timescale 1ns/1ps
module kbo_host (
	// Clock
	input wire logic       CLK,
	// Host strobes and byte
	output logic       CMD_WR,
	output logic       DATA_WR,
	output logic       OBUF_RD,
	output logic [7:0] HOST_DIN
);
	initial begin
		{CMD_WR, DATA_WR, OBUF_RD} = 3'h0;
		HOST_DIN = 8'($urandom);
	end
	// ==========
	// Command then data port
	task automatic put(input logic c, input logic d, input logic r, input logic [7:0] v);
		@(posedge CLK);
		{CMD_WR, DATA_WR, OBUF_RD, HOST_DIN} <= {c, d, r, v};
	endtask
	task automatic cmd(input logic [7:0] v);
		put(1'b1, 1'b0, 1'b0, v);
	endtask
	task automatic dat(input logic [7:0] v);
		put(1'b0, 1'b1, 1'b0, v);
	endtask
	task automatic rd();
		put(1'b0, 1'b0, 1'b1, 8'h00);
	endtask
	// Released bus inverts HOST_DIN as read at the call, before a same-step write lands, so the old byte can hold
	task automatic idle(input int n);
		repeat (n) put(1'b0, 1'b0, 1'b0, ~HOST_DIN);
	endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench of the command block
`timescale 1ns/1ps
module tb;
	// ==========
	// Signals
	localparam int PL = 4;
	logic       CLK, RSTN, CMD_WR, DATA_WR, OBUF_RD, KBD_DATA_IN, KBD_CLK_IN, PTR_DATA_IN, PTR_CLK_IN;
	logic       KBD_IRQ_EN, PTR_IRQ_EN, OBUF_FULL, OBUF_FROM_PTR, ADDR_BIT_TWENTY_GATE, SYS_RESET, PTR_TX_STB;
	logic       KEYBOARD_INTERRUPT_LINE, POINTER_INTERRUPT_LINE, gate;
	logic [1:0] TEST_IN;
	logic [3:0] PULSE_OUT;
	logic [7:0] HOST_DIN, INPUT_PORT, OBUF, STATUS_POLL, OUT_PORT, PTR_TX_DATA, b;
	logic [7:0] ptr_q[$];
	int         n_fail, n_tests;
	kbo_cmd #(.PULSE_LEN(PL)) uut (.CLK, .RSTN, .CMD_WR, .DATA_WR, .HOST_DIN, .OBUF_RD, .INPUT_PORT, .TEST_IN,
		.KBD_DATA_IN, .KBD_CLK_IN, .PTR_DATA_IN, .PTR_CLK_IN, .KBD_IRQ_EN, .PTR_IRQ_EN, .OBUF, .OBUF_FULL,
		.OBUF_FROM_PTR, .STATUS_POLL, .OUT_PORT, .ADDR_BIT_TWENTY_GATE, .SYS_RESET, .KEYBOARD_INTERRUPT_LINE,
		.POINTER_INTERRUPT_LINE, .PTR_TX_DATA, .PTR_TX_STB, .PULSE_OUT);
	kbo_host host (.CLK, .CMD_WR, .DATA_WR, .OBUF_RD, .HOST_DIN);
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	// Run takes about 360 cycles
	initial begin
		#300000;
		n_fail++;
		end_of_test();
	end
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic do_reset();
		RSTN <= 1'b0;
		repeat (4) @(posedge CLK);
		RSTN <= 1'b1;
		repeat (4) @(posedge CLK);
		#1;
		chk("gate reset", 8'h01, {7'h0, ADDR_BIT_TWENTY_GATE});
	endtask
	// Empty queue gives an unknown, so stray bytes fail
	always @(posedge CLK)
		if (PTR_TX_STB === 1'b1)
			chk("ptr byte", ptr_q.pop_front(), PTR_TX_DATA);
	initial begin
		RSTN = 1'b0;
		void'($urandom(32'hf8c1));
		{KBD_DATA_IN, KBD_CLK_IN, PTR_CLK_IN, PTR_DATA_IN, KBD_IRQ_EN, PTR_IRQ_EN} = 6'($urandom);
		TEST_IN = 2'($urandom);
		INPUT_PORT = 8'($urandom);
		do_reset();
		repeat (6) begin
			b = 8'($urandom);
			@(posedge CLK);
			{KBD_DATA_IN, KBD_CLK_IN, PTR_CLK_IN, PTR_DATA_IN} <= b[7:4];
			host.cmd(8'hd1);
			host.dat(b);
			host.idle(4);
			gate = b[1];
			host.cmd(8'hd0);
			host.idle(2);
			#1;
			chk("port image", {b[7:6], 2'b00, b[5:4], gate, 1'b0}, OBUF);
			chk("out port", {b[7:6], 2'b00, b[5:4], gate, 1'b0}, OUT_PORT);
			chk("buffer full", 8'h01, {7'h0, OBUF_FULL});
			chk("gate pin", {7'h0, gate}, {7'h0, ADDR_BIT_TWENTY_GATE});
			host.rd();
		end
		$display("test output port done");
		for (int i = 0; i < 4; i++) begin
			@(posedge CLK);
			TEST_IN <= 2'(i);
			host.cmd(8'he0);
			host.idle(2);
			#1;
			chk("test inputs", 8'(i), {6'h0, OBUF[1:0]});
		end
		$display("test inputs done");
		for (int i = 0; i < 8; i++) begin
			b = 8'($urandom);
			@(posedge CLK);
			{KBD_IRQ_EN, PTR_IRQ_EN} <= {i[1], i[2]};
			host.cmd(i[0] ? 8'hd3 : 8'hd2);
			host.idle(i);
			host.dat(b);
			host.idle(2);
			#1;
			chk("echo byte", b, OBUF);
			chk("echo flags", {5'h0, !i[0] && i[1], i[0] && i[2], i[0]},
				{5'h0, KEYBOARD_INTERRUPT_LINE, POINTER_INTERRUPT_LINE, OBUF_FROM_PTR});
			host.rd();
			host.idle(1);
			#1;
			chk("read clear", 8'h00, {5'h0, OBUF_FULL, KEYBOARD_INTERRUPT_LINE, POINTER_INTERRUPT_LINE});
		end
		$display("test echo done");
		repeat (4) begin
			b = 8'($urandom);
			ptr_q.push_back(b);
			host.cmd(8'hd4);
			host.dat(b);
			host.dat(~b);
		end
		host.idle(3);
		chk("ptr left", 8'h00, 8'(ptr_q.size()));
		$display("test pointer done");
		host.cmd(8'hc2);
		repeat (3) begin
			@(posedge CLK);
			INPUT_PORT <= 8'($urandom);
			host.idle(3);
			#1;
			chk("poll high", {INPUT_PORT[7:4], 4'h0}, {STATUS_POLL[7:4], 4'h0});
		end
		// High half must freeze once the next command lands
		b = INPUT_PORT;
		host.cmd(8'hc3);
		repeat (5) begin
			@(posedge CLK);
			INPUT_PORT <= 8'($urandom);
			host.idle(3);
			#1;
			chk("poll", {b[7:4], INPUT_PORT[3:0]}, STATUS_POLL);
		end
		$display("test poll done");
		for (int i = 0; i < 16; i++) begin
			host.cmd({4'hf, 4'(i)});
			host.idle(2);
			#1;
			chk("pulse", {4'h0, ~4'(i)}, {4'h0, PULSE_OUT});
			chk("sys reset", {7'h0, !i[0]}, {7'h0, SYS_RESET});
			chk("pulse port", {6'h0, gate ^ !i[1], !i[0]}, {6'h0, OUT_PORT[1:0]});
			host.idle(PL + 1);
			#1;
			chk("pulse end", 8'h00, {4'h0, PULSE_OUT});
		end
		$display("test pulse done");
		do_reset();
		end_of_test();
	end
endmodule
